// ### verilog/pt_pkg.sv
// Purpose: shared constants and types for the period timer with scalers
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: printed offsets are register indexes; byte address is four times the index
package pt_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indexes, byte address = index * 4
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 12'h00c;
  localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h011;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h012;
  localparam logic [ADDR_W-1:0] IDX_PERIOD = 12'h092;
  localparam int unsigned IDX_LSB = 2;

  // control field layout
  localparam int unsigned CTL_W = 7;
  localparam int unsigned PRE_LSB = 0;
  localparam int unsigned PRE_MSB = 1;
  localparam int unsigned ON_BIT = 2;
  localparam int unsigned POST_LSB = 3;
  localparam int unsigned POST_MSB = 6;
  localparam int unsigned FLAG_BIT = 1;

  // reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [CTL_W-1:0] CTL_RST = 7'h00;

  // prescaler terminal counts (ratio minus one)
  localparam logic [3:0] PRE_TC_1 = 4'h0;
  localparam logic [3:0] PRE_TC_4 = 4'h3;
  localparam logic [3:0] PRE_TC_16 = 4'hf;

  // instruction clock is the device clock divided by four
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned DIV_W = 2;

  typedef struct packed {
    logic [7:0] count;
    logic match;
  } pt_time_base_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [7:0] count;
    logic [7:0] period;
    logic [CTL_W-1:0] ctrl;
    logic flag;
    logic match;
    logic [DATA_W-1:0] rdata;
  } pt_state_t;
endpackage

// ### verilog/pt_timer.sv
// Purpose: 8-bit period timer with prescaler, period match and postscaled flag, apb registers
// Assumes: pclk is the oscillator clock; one instruction tick every four pclk cycles
// Notes: pready is always high, so every transfer completes in its first access cycle
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module pt_timer #(
  parameter int unsigned INSTR_DIV = pt_pkg::INSTR_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pt_pkg::ADDR_W-1:0] paddr,
  input wire logic [pt_pkg::DATA_W-1:0] pwdata,
  output logic [pt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic shift_clock_match,
  output pt_pkg::pt_time_base_t pwm_time_base,
  output logic match_flag
);

  localparam logic [pt_pkg::DIV_W-1:0] DIV_TC = pt_pkg::DIV_W'(INSTR_DIV - 1);

  pt_pkg::pt_state_t state_ff;
  pt_pkg::pt_state_t nxt_state;

  // word index from a byte address; low two bits ignored
  function automatic logic [pt_pkg::ADDR_W-1:0] reg_index(input logic [pt_pkg::ADDR_W-1:0] a);
    reg_index = {{pt_pkg::IDX_LSB{1'b0}}, a[pt_pkg::ADDR_W-1:pt_pkg::IDX_LSB]};
  endfunction

  function automatic logic is_mapped(input logic [pt_pkg::ADDR_W-1:0] a);
    logic [pt_pkg::ADDR_W-1:0] i;
    i = reg_index(a);
    is_mapped = (i == pt_pkg::IDX_FLAGS) || (i == pt_pkg::IDX_COUNT) ||
                (i == pt_pkg::IDX_CONTROL) || (i == pt_pkg::IDX_PERIOD);
  endfunction

  logic setup_rd;
  logic access;
  logic wr_ok;
  logic wr_count;
  logic wr_ctrl;
  logic wr_period;
  logic wr_flags;
  logic inst_tick;
  logic [3:0] pre_tc;
  logic pre_tick;
  logic cnt_tick;
  logic at_period;
  logic post_done;
  logic set_flag;

  assign pready = 1'b1;
  assign access = psel & penable;
  assign pslverr = access & ~is_mapped(paddr);
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_ok = access & pwrite & is_mapped(paddr);
  assign wr_count = wr_ok & (reg_index(paddr) == pt_pkg::IDX_COUNT);
  assign wr_ctrl = wr_ok & (reg_index(paddr) == pt_pkg::IDX_CONTROL);
  assign wr_period = wr_ok & (reg_index(paddr) == pt_pkg::IDX_PERIOD);
  assign wr_flags = wr_ok & (reg_index(paddr) == pt_pkg::IDX_FLAGS);

  assign prdata = state_ff.rdata;
  assign shift_clock_match = state_ff.match;
  // pwm time base, one driver for the whole struct
  assign pwm_time_base = '{count: state_ff.count, match: state_ff.match};
  assign match_flag = state_ff.flag;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.match = 1'b0;
    // divider runs free so the instruction phase is independent of software writes
    inst_tick = (state_ff.div == DIV_TC);
    nxt_state.div = inst_tick ? '0 : state_ff.div + 1'b1;

    if (state_ff.ctrl[pt_pkg::PRE_MSB]) begin
      pre_tc = pt_pkg::PRE_TC_16;
    end else if (state_ff.ctrl[pt_pkg::PRE_LSB]) begin
      pre_tc = pt_pkg::PRE_TC_4;
    end else begin
      pre_tc = pt_pkg::PRE_TC_1;
    end

    pre_tick = 1'b0;
    if (state_ff.ctrl[pt_pkg::ON_BIT] && inst_tick) begin
      if (state_ff.pre_cnt >= pre_tc) begin
        pre_tick = 1'b1;
        nxt_state.pre_cnt = '0;
      end else begin
        nxt_state.pre_cnt = state_ff.pre_cnt + 1'b1;
      end
    end
    cnt_tick = pre_tick;

    at_period = (state_ff.count == state_ff.period);
    post_done = 1'b0;
    if (cnt_tick) begin
      if (at_period) begin
        nxt_state.count = '0;
        nxt_state.match = 1'b1;
        if (state_ff.post_cnt >= state_ff.ctrl[pt_pkg::POST_MSB:pt_pkg::POST_LSB]) begin
          post_done = 1'b1;
          nxt_state.post_cnt = '0;
        end else begin
          nxt_state.post_cnt = state_ff.post_cnt + 1'b1;
        end
      end else begin
        nxt_state.count = state_ff.count + 1'b1;
      end
    end
    set_flag = post_done;

    // software write to count wins over a tick
    if (wr_count) begin
      nxt_state.count = pwdata[7:0];
    end
    // scaler clear on count or control write
    if (wr_count || wr_ctrl) begin
      nxt_state.pre_cnt = '0;
      nxt_state.post_cnt = '0;
    end
    // control write keeps count; bit 7 not stored
    if (wr_ctrl) begin
      nxt_state.ctrl = pwdata[pt_pkg::CTL_W-1:0];
    end
    if (wr_period) begin
      nxt_state.period = pwdata[7:0];
    end
    // hardware set beats a software clear in the same cycle
    if (set_flag) begin
      nxt_state.flag = 1'b1;
    end else if (wr_flags) begin
      nxt_state.flag = pwdata[pt_pkg::FLAG_BIT];
    end

    // read data captured in setup phase, held through access
    if (setup_rd) begin
      nxt_state.rdata = '0;
      unique case (reg_index(paddr))
        pt_pkg::IDX_FLAGS: nxt_state.rdata[pt_pkg::FLAG_BIT] = state_ff.flag;
        pt_pkg::IDX_COUNT: nxt_state.rdata[7:0] = state_ff.count;
        pt_pkg::IDX_CONTROL: nxt_state.rdata[pt_pkg::CTL_W-1:0] = state_ff.ctrl;
        pt_pkg::IDX_PERIOD: nxt_state.rdata[7:0] = state_ff.period;
        default: nxt_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff.div <= '0;
      state_ff.pre_cnt <= '0;
      state_ff.post_cnt <= '0;
      state_ff.count <= pt_pkg::COUNT_RST;
      state_ff.period <= pt_pkg::PERIOD_RST;
      state_ff.ctrl <= pt_pkg::CTL_RST;
      state_ff.flag <= 1'b0;
      state_ff.match <= 1'b0;
      state_ff.rdata <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ### dv/pt_timer_properties.sv
// Purpose: port checks for the period timer
// Assumes: pready is always high, so writes land at the access edge
// Notes: on state is tracked from control writes, a cheap copy of the register
`timescale 1ns/100ps
module pt_timer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pt_pkg::ADDR_W-1:0] paddr,
  input wire logic [pt_pkg::DATA_W-1:0] pwdata,
  input wire logic shift_clock_match,
  input wire pt_pkg::pt_time_base_t pwm_time_base,
  input wire logic match_flag
);
  logic wr, wc, wf, on_ff;
  logic [7:0] wd;
  assign wr = psel && penable && pwrite;
  assign wc = wr && {2'h0, paddr[11:2]} == pt_pkg::IDX_COUNT;
  assign wf = wr && {2'h0, paddr[11:2]} == pt_pkg::IDX_FLAGS;
  assign wd = pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_ff <= 1'h0;
    else if (wr && {2'h0, paddr[11:2]} == pt_pkg::IDX_CONTROL) on_ff <= pwdata[2];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SAME: assert property (shift_clock_match == pwm_time_base.match)
    else $error("match outputs differ");
  AST_ZERO: assert property (shift_clock_match && !$past(wc) |-> pwm_time_base.count == 8'h00)
    else $error("match with nonzero count");
  AST_STEP: assert property ($changed(pwm_time_base.count) && !$past(wc) |->
    pwm_time_base.count == $past(pwm_time_base.count) + 8'h01 || pwm_time_base.count == 8'h00)
    else $error("count jumped");
  AST_HOLD: assert property ($past(match_flag) && !$past(wf) |-> match_flag)
    else $error("flag dropped");
  AST_SET: assert property ($rose(match_flag) && !$past(wf) |-> shift_clock_match)
    else $error("flag without match");
  AST_RST: assert property ($rose(presetn) |-> pwm_time_base.count == 8'h00 && !match_flag)
    else $error("reset state wrong");
  AST_OFF: assert property (!on_ff && !wc |=> $stable(pwm_time_base.count))
    else $error("count moved while off");
  AST_WCNT: assert property (wc |=> pwm_time_base.count == $past(wd))
    else $error("count write lost");
  cover property ($rose(match_flag));
  cover property (shift_clock_match);
  cover property (wc);
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench for the period timer
// Assumes: default instruction divider, so match spacing scales with it
// Notes: random periods and one random postscale value (others 0 and 15) from a fixed seed
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, shift_clock_match, match_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pt_pkg::pt_time_base_t pwm_time_base;
  int mismatches, checked, c, k, n, p, pre;
  pt_timer #(.INSTR_DIV(pt_pkg::INSTR_DIV)) pt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_match(shift_clock_match),
    .pwm_time_base(pwm_time_base), .match_flag(match_flag));
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task late;
    mismatches++;
    complete_run();
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    // hold the request until pready is seen at an edge
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) late();
    rd = prdata;
    {psel, penable} <= 2'h0;
  endtask
  task waitm;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (shift_clock_match !== 1'h1 && c < 999);
    if (shift_clock_match !== 1'h1) late();
  endtask
  function int ratio(input int s);
    return (s == 0) ? 1 : (s == 1) ? 4 : 16;
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    checked = 0;
    c = $urandom(71880);
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    bus(1'h0, 12'h044, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h248, 32'h0);
    chk(rd, 32'hff);
    bus(1'h0, 12'h030, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 12'h048, 32'hff);
    bus(1'h0, 12'h048, 32'h0);
    chk(rd, 32'h7f);
    bus(1'h0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 12'h048, 32'h0);
    bus(1'h1, 12'h044, 32'h5a);
    bus(1'h1, 12'h048, 32'h78);
    bus(1'h0, 12'h044, 32'h0);
    chk(rd, 32'h5a);
    $display("register test done");
    for (pre = 0; pre < 4; pre++) begin
      p = $urandom_range(7, 1);
      bus(1'h1, 12'h248, p);
      bus(1'h1, 12'h044, 32'h0);
      bus(1'h1, 12'h048, 32'h4 | pre);
      waitm();
      waitm();
      // match to match spacing in pclk cycles
      chk(c, (p + 1) * ratio(pre) * pt_pkg::INSTR_DIV);
    end
    $display("prescale test done");
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(14, 1);
      bus(1'h1, 12'h048, 32'h0);
      bus(1'h1, 12'h030, 32'h0);
      // the clear lands at the access edge, so look one edge later
      @(posedge pclk);
      chk({31'h0, match_flag}, 32'h0);
      bus(1'h1, 12'h044, 32'h0);
      bus(1'h1, 12'h048, 32'h4 | (n << 3));
      p = 0;
      do begin
        waitm();
        p++;
      end while (match_flag !== 1'h1 && p < 20);
      if (match_flag !== 1'h1) late();
      chk(p, n + 1);
      waitm();
      bus(1'h0, 12'h030, 32'h0);
      chk(rd, 32'h2);
    end
    $display("postscale test done");
    bus(1'h1, 12'h248, 32'h3);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    bus(1'h0, 12'h248, 32'h0);
    chk(rd, 32'hff);
    bus(1'h0, 12'h044, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h048, 32'h0);
    chk(rd, 32'h0);
    $display("second reset test done");
    complete_run();
  end
endmodule
bind pt_timer pt_timer_properties pt_timer_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .shift_clock_match(shift_clock_match), .pwm_time_base(pwm_time_base), .match_flag(match_flag));
